// File: rtl/rfc_pkg.sv
// Constants, register map and state encoding of the RF channel checksum unit.
package rfc_pkg;
	// ------------------------------------------------------------------
	// Register indices; byte address is four times the index.
	// ------------------------------------------------------------------
	localparam logic [5:0] IDX_CFG       = 6'h22;
	localparam logic [5:0] IDX_SEED_LO   = 6'h23;
	localparam logic [5:0] IDX_SEED_HI   = 6'h24;
	localparam logic [5:0] IDX_SLOT_LO   = 6'h25;
	localparam logic [5:0] IDX_SLOT_TOP  = 6'h26;
	localparam logic [5:0] IDX_STATUS    = 6'h30;
	localparam logic [5:0] IDX_IRQ_STAT  = 6'h31;
	localparam logic [5:0] IDX_IRQ_CLR   = 6'h32;
	localparam logic [5:0] IDX_IRQ_EN    = 6'h33;
	localparam logic [5:0] IDX_CMD       = 6'h34;
	localparam logic [5:0] IDX_RES_LO    = 6'h35;
	localparam logic [5:0] IDX_RES_HI    = 6'h36;
	localparam logic [5:0] IDX_CALC_DATA = 6'h37;
	// ------------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------------
	localparam int         CFG_MSB_FIRST  = 6;
	localparam int         CFG_HDLC       = 5;
	localparam int         CFG_SHORT      = 4;
	localparam int         CFG_RX_EN      = 3;
	localparam int         CFG_TX_EN      = 2;
	localparam logic [7:0] CFG_MASK       = 8'h7c;
	localparam logic [7:0] CFG_RESET      = 8'h0c;
	localparam logic [7:0] SEED_LO_RESET  = 8'hfe;
	localparam logic [7:0] SEED_HI_RESET  = 8'hff;
	localparam logic [7:0] SLOT_LO_RESET  = 8'h00;
	localparam int         SLOT_TOP_BIT   = 4;
	localparam int         CMD_CALC_BIT   = 0;
	localparam int         ST_ERR_BIT     = 0;
	localparam int         ST_TX_BIT      = 1;
	localparam int         ST_RX_BIT      = 2;
	localparam int         ST_SLOT_BIT    = 3;
	localparam int         IRQ_W          = 4;
	localparam int         IRQ_CHK_ERR    = 0;
	localparam int         IRQ_RX_DONE    = 1;
	localparam int         IRQ_TX_DONE    = 2;
	localparam int         IRQ_SLOT       = 3;
	// ------------------------------------------------------------------
	// Generator polynomials; plain and reflected forms.
	// ------------------------------------------------------------------
	localparam logic [15:0] POLY16     = 16'h1021;
	localparam logic [15:0] POLY16_REV = 16'h8408;
	localparam logic [7:0]  POLY8      = 8'h1d;
	localparam logic [7:0]  POLY8_REV  = 8'hb8;

	typedef enum logic [2:0] {
		RFC_IDLE = 3'b000,
		RFC_TX   = 3'b001,
		RFC_CRC1 = 3'b011,
		RFC_CRC2 = 3'b010,
		RFC_RX   = 3'b110
	} rfc_state_t;
endpackage : rfc_pkg

// File: rtl/rfc_crc_if.sv
// Link between the channel controller and its checksum engine.
`timescale 1ns/100ps
interface rfc_crc_if;
	logic        init;       // Load seed.
	logic [15:0] seed;       // Seed value.
	logic        feed;       // Absorb one byte.
	logic [7:0]  data;       // Byte to absorb.
	logic        short_sel;  // 8-bit checksum.
	logic        msb_first;  // Bit order.
	logic        hdlc;       // Reflected, inverted variant.
	logic [15:0] crc;        // Checksum as transmitted.

	modport eng (input init, seed, feed, data, short_sel, msb_first, hdlc, output crc);
	modport user (output init, seed, feed, data, short_sel, msb_first, hdlc, input crc);
endinterface : rfc_crc_if

// File: rtl/rfc_crc_engine.sv
// Byte-wide checksum engine with selectable width, bit order and variant.
`timescale 1ns/100ps
module rfc_crc_engine
	import rfc_pkg::*;
(
	input  wire logic clk,   // Device clock.
	input  wire logic nrst,  // Asynchronous reset, active low.
	rfc_crc_if.eng    cif    // Control and result.
);
	logic [15:0] crc_q;
	logic [15:0] next_crc;

	function automatic logic [15:0] rfc_step(input logic [15:0] c_in, input logic [7:0] d,
			input logic msb, input logic sh, input logic hd);
		logic [15:0] c;
		logic        b;
		logic        fb;
		c = c_in;
		for (int i = 0; i < 8; i++) begin
			b = msb ? d[7 - i] : d[i];
			if (hd) begin
				fb = c[0] ^ b;
				c = sh ? {8'h00, (c[7:0] >> 1) ^ (fb ? POLY8_REV : 8'h00)}
					: (c >> 1) ^ (fb ? POLY16_REV : 16'h0000);
			end else begin
				fb = (sh ? c[7] : c[15]) ^ b;
				c = sh ? {8'h00, {c[6:0], 1'b0} ^ (fb ? POLY8 : 8'h00)}
					: {c[14:0], 1'b0} ^ (fb ? POLY16 : 16'h0000);
			end
		end
		return c;
	endfunction : rfc_step

	always_comb begin
		next_crc = crc_q;
		if (cif.init) begin
			next_crc = cif.short_sel ? {8'h00, cif.seed[7:0]} : cif.seed;
		end else if (cif.feed) begin
			next_crc = rfc_step(crc_q, cif.data, cif.msb_first, cif.short_sel, cif.hdlc);
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			crc_q <= 16'h0000;
		end else begin
			crc_q <= next_crc;
		end
	end

	// The inverted variant is only inverted on the way out, so the register keeps the seed.
	assign cif.crc = cif.short_sel ? {8'h00, cif.hdlc ? ~crc_q[7:0] : crc_q[7:0]}
		: (cif.hdlc ? ~crc_q : crc_q);

	a_seed_load: assert property (@(posedge clk) disable iff (!nrst)
		cif.init |=> crc_q == ($past(cif.short_sel) ? {8'h00, $past(cif.seed[7:0])}
		: $past(cif.seed))) else $error("seed not loaded");
	a_msb_order: assert property (@(posedge clk) disable iff (!nrst)
		cif.feed && !cif.init && crc_q == 16'h0000 && cif.data == 8'h01 && cif.msb_first
		&& !cif.short_sel && !cif.hdlc |=> crc_q == POLY16)
		else $error("bit order wrong");
	a_hdlc_step: assert property (@(posedge clk) disable iff (!nrst)
		cif.feed && !cif.init && crc_q == 16'h0000 && cif.data == 8'h01 && cif.msb_first
		&& !cif.short_sel && cif.hdlc |=> crc_q == POLY16_REV)
		else $error("reflected variant wrong");
endmodule : rfc_crc_engine

// File: rtl/rfc_channel.sv
// RF channel checksum unit: append, check and strip, seeds, slot timing, registers.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/100ps
// Functional notes
// - Bit order select: one feeds MSB first.
// - HDLC mode selects the reflected 3309 variant.
// - Short select gives 8-bit, else 16-bit checksum.
// - Receive check: final bytes are the checksum.
// - Verified checksum bytes never reach FIFO.
// - Receive mismatch sets check error flag.
// - Transmit append adds checksum after data.
// - Seed loaded at each frame with checksum enabled and at command.
// - Seed resets to low FE, high FF.
// - 8-bit width uses low seed byte only.
// - Slot interval spaces automatic frames.
// - Slot timing starts at command transmit end.
// - Slot interval has ninth bit elsewhere.
module rfc_channel
	import rfc_pkg::*;
(
	input  wire logic        clk,             // Device clock, 50 MHz.
	input  wire logic        nrst,            // Asynchronous reset, active low.
	input  wire logic [7:0]  avs_address,     // Byte address.
	input  wire logic        avs_read,        // Read request.
	input  wire logic        avs_write,       // Write request.
	input  wire logic [31:0] avs_writedata,   // Write data.
	input  wire logic [3:0]  avs_byteenable,  // Byte lanes.
	output logic      [31:0] avs_readdata,    // Read data.
	output logic             avs_waitrequest, // Stall.
	output logic             irq,             // Level interrupt.
	input  wire logic        tx_start,        // Transmit frame begins.
	input  wire logic        tx_in_valid,     // Payload byte offered.
	input  wire logic [7:0]  tx_in_data,      // Payload byte.
	input  wire logic        tx_in_last,      // Last payload byte.
	output logic             tx_in_ready,     // Payload byte taken.
	output logic             tx_out_valid,    // Byte to coder.
	output logic      [7:0]  tx_out_data,     // Byte to coder.
	output logic             tx_out_last,     // Last byte of frame.
	input  wire logic        tx_out_ready,    // Coder takes byte.
	input  wire logic        rx_start,        // Reception begins.
	input  wire logic        rx_in_valid,     // Received byte.
	input  wire logic [7:0]  rx_in_data,      // Received byte.
	input  wire logic        rx_in_last,      // Last received byte.
	output logic             rx_out_valid,    // Byte to FIFO.
	output logic      [7:0]  rx_out_data,     // Byte to FIFO.
	output logic             rx_done,         // Frame ended.
	input  wire logic        slot_tick,       // Slot time base.
	input  wire logic        slot_stop,       // Stop automatic frames.
	output logic             auto_frame_req   // Send next automatic frame.
);
	// ------------------------------------------------------------------
	// Register bus.
	// ------------------------------------------------------------------
	logic             ack;
	logic             req;
	logic             wr_en;
	logic [5:0]       idx;
	logic [7:0]       wd;
	logic [7:0]       rd_mux;
	logic [7:0]       cfg;
	logic [7:0]       seed_lo;
	logic [7:0]       seed_hi;
	logic [7:0]       slot_lo;
	logic             slot_top;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	logic [IRQ_W-1:0] irq_ev;
	logic [IRQ_W-1:0] irq_clr;
	logic             check_error_flag;
	rfc_state_t       state;
	logic             slot_run;
	logic [8:0]       slot_cnt;
	logic [8:0]       slot_interval;
	rfc_crc_if        cif ();

	assign req = avs_read | avs_write;
	// One wait cycle per access keeps read data registered.
	assign avs_waitrequest = req & ~ack;
	assign idx = avs_address[7:2];
	assign wd = avs_writedata[7:0];
	assign wr_en = avs_write & ack & avs_byteenable[0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	always_comb begin
		rd_mux = 8'h00;
		case (idx)
			IDX_CFG:      rd_mux = cfg;
			IDX_SEED_LO:  rd_mux = seed_lo;
			IDX_SEED_HI:  rd_mux = seed_hi;
			IDX_SLOT_LO:  rd_mux = slot_lo;
			IDX_SLOT_TOP: rd_mux = {3'h0, slot_top, 4'h0};
			IDX_STATUS:   rd_mux = {4'h0, slot_run, state == RFC_RX,
				state != RFC_IDLE && state != RFC_RX, check_error_flag};
			IDX_IRQ_STAT: rd_mux = {4'h0, irq_stat};
			IDX_IRQ_EN:   rd_mux = {4'h0, irq_en};
			IDX_RES_LO:   rd_mux = cif.crc[7:0];
			IDX_RES_HI:   rd_mux = cif.crc[15:8];
			default:      rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack) begin
			avs_readdata <= {24'h00_0000, rd_mux};
		end
	end

	// Reserved configuration bits are not stored and read back as zero.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg      <= CFG_RESET;
			seed_lo  <= SEED_LO_RESET;
			seed_hi  <= SEED_HI_RESET;
			slot_lo  <= SLOT_LO_RESET;
			slot_top <= 1'b0;
			irq_en   <= '0;
		end else if (wr_en) begin
			case (idx)
				IDX_CFG:      cfg <= wd & CFG_MASK;
				IDX_SEED_LO:  seed_lo <= wd;
				IDX_SEED_HI:  seed_hi <= wd;
				IDX_SLOT_LO:  slot_lo <= wd;
				IDX_SLOT_TOP: slot_top <= wd[SLOT_TOP_BIT];
				IDX_IRQ_EN:   irq_en <= wd[IRQ_W-1:0];
				default:      ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Checksum engine control.
	// ------------------------------------------------------------------
	logic tx_append;
	logic rx_chk;
	logic short_sel;
	logic tx_go;
	logic rx_go;
	logic calc_go;
	logic calc_feed;
	logic out_free;
	logic tx_acc;
	logic tx_done;
	logic rx_byte;
	logic rx_exit;
	logic rx_pass;
	logic rx_match;
	logic chk_err_ev;
	logic [7:0] held;
	logic       held_v;

	assign tx_append = cfg[CFG_TX_EN];
	assign rx_chk    = cfg[CFG_RX_EN];
	assign short_sel = cfg[CFG_SHORT];
	assign tx_go     = state == RFC_IDLE && tx_start;
	assign rx_go     = state == RFC_IDLE && !tx_start && rx_start;
	assign calc_go   = wr_en && idx == IDX_CMD && wd[CMD_CALC_BIT] && state == RFC_IDLE;
	assign calc_feed = wr_en && idx == IDX_CALC_DATA && state == RFC_IDLE;

	assign cif.short_sel = short_sel;
	assign cif.msb_first = cfg[CFG_MSB_FIRST];
	assign cif.hdlc      = cfg[CFG_HDLC];
	assign cif.seed      = {seed_hi, seed_lo};
	assign cif.init      = (tx_go & tx_append) | (rx_go & rx_chk) | calc_go;
	assign cif.feed      = (tx_acc & tx_append) | rx_exit | calc_feed;
	assign cif.data      = tx_acc ? tx_in_data : (rx_exit ? (short_sel ? rx_in_data : held) : wd);

	rfc_crc_engine u_engine (
		.clk  (clk),
		.nrst (nrst),
		.cif  (cif)
	);

	// ------------------------------------------------------------------
	// Frame sequencing.
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= RFC_IDLE;
		end else begin
			case (state)
				RFC_IDLE: begin
					if (tx_go) begin
						state <= RFC_TX;
					end else if (rx_go) begin
						state <= RFC_RX;
					end
				end
				RFC_TX: begin
					if (tx_acc && tx_in_last) begin
						state <= tx_append ? RFC_CRC1 : RFC_IDLE;
					end
				end
				RFC_CRC1: begin
					if (out_free) begin
						state <= short_sel ? RFC_IDLE : RFC_CRC2;
					end
				end
				RFC_CRC2: begin
					if (out_free) begin
						state <= RFC_IDLE;
					end
				end
				RFC_RX: begin
					if (rx_byte && rx_in_last) begin
						state <= RFC_IDLE;
					end
				end
				default: state <= RFC_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Transmit path; the checksum goes out low byte first.
	// ------------------------------------------------------------------
	assign out_free    = ~tx_out_valid | tx_out_ready;
	assign tx_in_ready = state == RFC_TX && out_free;
	assign tx_acc      = tx_in_valid & tx_in_ready;
	assign tx_done     = tx_out_valid & tx_out_ready & tx_out_last;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_out_valid <= 1'b0;
			tx_out_data  <= 8'h00;
			tx_out_last  <= 1'b0;
		end else if (tx_acc) begin
			tx_out_valid <= 1'b1;
			tx_out_data  <= tx_in_data;
			tx_out_last  <= tx_in_last & ~tx_append;
		end else if (state == RFC_CRC1 && out_free) begin
			tx_out_valid <= 1'b1;
			tx_out_data  <= cif.crc[7:0];
			tx_out_last  <= short_sel;
		end else if (state == RFC_CRC2 && out_free) begin
			tx_out_valid <= 1'b1;
			tx_out_data  <= cif.crc[15:8];
			tx_out_last  <= 1'b1;
		end else if (tx_out_ready) begin
			tx_out_valid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Receive path. With a 16-bit check the newest byte is held back until
	// the frame shows whether it is payload or checksum.
	// ------------------------------------------------------------------
	assign rx_byte  = state == RFC_RX && rx_in_valid;
	assign rx_exit  = rx_byte & ~rx_in_last & rx_chk & (short_sel | held_v);
	assign rx_pass  = rx_byte & (rx_chk ? (~rx_in_last & (short_sel | held_v)) : 1'b1);
	assign rx_match = short_sel ? (rx_in_data == cif.crc[7:0])
		: (held_v && {rx_in_data, held} == cif.crc);
	assign chk_err_ev = rx_byte & rx_in_last & rx_chk & ~rx_match;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			held   <= 8'h00;
			held_v <= 1'b0;
		end else if (rx_go) begin
			held_v <= 1'b0;
		end else if (rx_byte && !rx_in_last && rx_chk && !short_sel) begin
			held   <= rx_in_data;
			held_v <= 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_out_valid <= 1'b0;
			rx_out_data  <= 8'h00;
			rx_done      <= 1'b0;
		end else begin
			rx_out_valid <= rx_pass;
			rx_done      <= rx_byte & rx_in_last;
			if (rx_pass) begin
				rx_out_data <= (rx_chk && !short_sel) ? held : rx_in_data;
			end
		end
	end

	// An error arriving with a clear keeps the flag set.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			check_error_flag <= 1'b0;
		end else if (chk_err_ev) begin
			check_error_flag <= 1'b1;
		end else if (rx_go) begin
			check_error_flag <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Slot timer for automatic frames.
	// ------------------------------------------------------------------
	assign slot_interval = {slot_top, slot_lo};

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slot_run <= 1'b0;
			slot_cnt <= 9'h000;
		end else if (slot_stop) begin
			slot_run <= 1'b0;
		end else if (tx_done && slot_interval != 9'h000) begin
			slot_run <= 1'b1;
			slot_cnt <= slot_interval;
		end else if (slot_run && slot_tick) begin
			if (slot_cnt == 9'h001) begin
				slot_cnt <= slot_interval;
				slot_run <= slot_interval != 9'h000;
			end else begin
				slot_cnt <= slot_cnt - 9'h001;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			auto_frame_req <= 1'b0;
		end else begin
			auto_frame_req <= slot_run & slot_tick & slot_cnt == 9'h001 & ~slot_stop
				& ~tx_done;
		end
	end

	// ------------------------------------------------------------------
	// Interrupts.
	// ------------------------------------------------------------------
	assign irq_ev = {auto_frame_req, tx_done, rx_byte & rx_in_last, chk_err_ev};
	assign irq_clr = (wr_en && idx == IDX_IRQ_CLR) ? wd[IRQ_W-1:0] : '0;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
		end
	end

	assign irq = |(irq_stat & irq_en);

	// ------------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------------
	a_tx_no_append: assert property (@(posedge clk) disable iff (!nrst)
		tx_acc && tx_in_last && !tx_append |=> tx_out_valid && tx_out_last
		&& state == RFC_IDLE) else $error("checksum sent while disabled");
	a_tx_crc_byte: assert property (@(posedge clk) disable iff (!nrst)
		state == RFC_CRC1 && out_free |=> tx_out_valid && tx_out_data == $past(cif.crc[7:0])
		&& tx_out_last == $past(short_sel)) else $error("checksum byte wrong");
	a_tx_append_seq: assert property (@(posedge clk) disable iff (!nrst)
		tx_acc && tx_in_last && tx_append |=> state == RFC_CRC1 && !tx_out_last)
		else $error("append did not start");
	a_rx_strip: assert property (@(posedge clk) disable iff (!nrst)
		rx_byte && rx_in_last && rx_chk |=> !rx_out_valid && rx_done)
		else $error("checksum byte passed to fifo");
	a_rx_plain: assert property (@(posedge clk) disable iff (!nrst)
		rx_byte && !rx_chk |=> rx_out_valid && rx_out_data == $past(rx_in_data))
		else $error("plain byte not passed");
	a_chk_err: assert property (@(posedge clk) disable iff (!nrst)
		chk_err_ev |=> check_error_flag && irq_stat[IRQ_CHK_ERR])
		else $error("check error not flagged");
	a_err_clear: assert property (@(posedge clk) disable iff (!nrst)
		rx_go |=> !check_error_flag) else $error("error flag not cleared");
	a_slot_start: assert property (@(posedge clk) disable iff (!nrst)
		tx_done && !slot_stop && slot_interval != 9'h000 |=> slot_run
		&& slot_cnt == $past(slot_interval)) else $error("slot timer not started");
	a_slot_fire: assert property (@(posedge clk) disable iff (!nrst)
		slot_run && slot_tick && slot_cnt == 9'h001 && !slot_stop && !tx_done
		|=> auto_frame_req) else $error("automatic frame missed");
endmodule : rfc_channel

// File: dv/rfc_label_model.sv
// Far-side model: the coder that takes transmit bytes and a label that sends frames.
`timescale 1ns/100ps
module rfc_label_model (
	input  wire logic       clk,          // Device clock.
	output logic            tx_out_ready, // Coder takes byte.
	output logic            rx_in_valid,  // Label byte valid.
	output logic      [7:0] rx_in_data,   // Label byte.
	output logic            rx_in_last    // Final label byte.
);
	int seed = 32'h3acb;
	initial {rx_in_valid, rx_in_data, rx_in_last} = 10'h000;
	// Random stalls make the design hold some output bytes for a while.
	always @(posedge clk) tx_out_ready <= ($random(seed) % 4) != 0;
	task automatic send(input logic [7:0] f[$]);
		foreach (f[i]) begin
			rx_in_valid <= 1'b1;
			rx_in_data  <= f[i];
			rx_in_last  <= i == f.size() - 1;
			@(posedge clk);
		end
		rx_in_valid <= 1'b0;
		rx_in_last  <= 1'b0;
		// The released line toggles so that a stale byte cannot pass for data.
		rx_in_data  <= ~rx_in_data;
	endtask : send
endmodule : rfc_label_model

// File: dv/testbench.sv
// Self-checking bench of the RF channel checksum unit.
`timescale 1ns/100ps
module testbench;
	import rfc_pkg::*;
	logic        clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, tx_start = 1'b0;
	logic        tx_in_valid = 1'b0, tx_in_last = 1'b0, rx_start = 1'b0, slot_tick = 1'b0;
	logic        avs_waitrequest, irq, tx_in_ready, tx_out_valid, tx_out_last, tx_out_ready;
	logic        rx_in_valid, rx_in_last, rx_out_valid, rx_done, auto_frame_req;
	logic [7:0]  avs_address = 8'h00, tx_in_data = 8'h00, tx_out_data, rx_in_data, rx_out_data;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [15:0] sd;
	logic [8:0]  txq[$];
	logic [7:0]  rxq[$], rdq[$], pl[$];
	logic [7:0]  modes[6] = '{8'h4c, 8'h0c, 8'h2c, 8'h5c, 8'h1c, 8'h3c};
	int          num_errors = 0, checked = 0, seed = 32'h3acb, afr_cnt = 0;
	always #10 clk = ~clk;
	rfc_channel DUT (.*, .avs_byteenable(4'hf), .slot_stop(1'b0));
	rfc_label_model lbl (.*);
	// ----------------------------------------------------------------
	// Checking, bus and stream helpers.
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic conclude();
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	// A wait that runs out counts as a mismatch and ends the run.
	task automatic wait_lvl(ref logic sig, input logic lvl);
		int n;
		for (n = 0; n < 2000; n++) begin
			@(posedge clk);
			if (sig === lvl) break;
		end
		if (n == 2000) begin
			num_errors++;
			conclude();
		end
	endtask : wait_lvl
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d);
		avs_address   <= {idx, 2'b00};
		avs_writedata <= {24'h0, d};
		avs_read      <= !wr;
		avs_write     <= wr;
		wait_lvl(avs_waitrequest, 1'b0);
		avs_read      <= 1'b0;
		avs_write     <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
		rdq.push_back(exp);
		bus(1'b0, idx, 8'h00);
	endtask : rd
	function automatic logic [15:0] crc_calc(input logic [7:0] cfg, input logic [15:0] c);
		logic fb, s, b;
		s = cfg[CFG_SHORT];
		if (s) c[15:8] = 8'h00;
		foreach (pl[i]) begin
			for (int k = 0; k < 8; k++) begin
				b = cfg[CFG_MSB_FIRST] ? pl[i][7 - k] : pl[i][k];
				// Bit order picks the input bit; the variant picks the shift direction.
				if (cfg[CFG_HDLC]) begin
					fb = b ^ c[0];
					c  = (c >> 1) ^ (fb ? (s ? {8'h00, POLY8_REV} : POLY16_REV) : 16'h0000);
				end else begin
					fb = b ^ (s ? c[7] : c[15]);
					c  = (c << 1) ^ (fb ? (s ? {8'h00, POLY8} : POLY16) : 16'h0000);
				end
				if (s) c[15:8] = 8'h00;
			end
		end
		return cfg[CFG_HDLC] ? ~c : c;
	endfunction : crc_calc
	task automatic setup(input logic [7:0] cfg);
		sd = 16'($random(seed));
		if (cfg[CFG_HDLC]) sd[7:0] = 8'hff;
		bus(1'b1, IDX_CFG, cfg);
		rd(IDX_CFG, cfg);
		bus(1'b1, IDX_SEED_LO, sd[7:0]);
		bus(1'b1, IDX_SEED_HI, sd[15:8]);
		pl = {};
		repeat (1 + {$random(seed)} % 4) pl.push_back(8'($random(seed)));
	endtask : setup
	task automatic send_tx(input logic [7:0] cfg);
		logic [15:0] c;
		int          n;
		c = crc_calc(cfg, sd);
		foreach (pl[i]) txq.push_back({!cfg[CFG_TX_EN] && i == pl.size() - 1, pl[i]});
		if (cfg[CFG_TX_EN]) txq.push_back({cfg[CFG_SHORT], c[7:0]});
		if (cfg[CFG_TX_EN] && !cfg[CFG_SHORT]) txq.push_back({1'b1, c[15:8]});
		tx_start <= 1'b1;
		@(posedge clk);
		tx_start <= 1'b0;
		foreach (pl[i]) begin
			tx_in_valid <= 1'b1;
			tx_in_data  <= pl[i];
			tx_in_last  <= i == pl.size() - 1;
			wait_lvl(tx_in_ready, 1'b1);
		end
		tx_in_valid <= 1'b0;
		for (n = 0; n < 200 && txq.size() > 0; n++) @(posedge clk);
		if (txq.size() > 0) begin
			num_errors++;
			conclude();
		end
		@(posedge clk);
	endtask : send_tx
	task automatic send_rx(input logic [7:0] cfg, input logic bad);
		logic [15:0] c;
		logic [7:0]  f[$];
		c = crc_calc(cfg, sd);
		f = pl;
		foreach (pl[i]) rxq.push_back(pl[i]);
		if (cfg[CFG_RX_EN]) f.push_back(c[7:0] ^ {7'h00, bad});
		if (cfg[CFG_RX_EN] && !cfg[CFG_SHORT]) f.push_back(c[15:8]);
		rx_start <= 1'b1;
		@(posedge clk);
		rx_start <= 1'b0;
		lbl.send(f);
		wait_lvl(rx_done, 1'b1);
		rd(IDX_STATUS, {7'h00, bad});
	endtask : send_rx
	task automatic ticks(input int n);
		repeat (n) begin
			slot_tick <= 1'b1;
			@(posedge clk);
			slot_tick <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : ticks
	always @(posedge clk) begin
		if (avs_read && !avs_waitrequest) check("register", avs_readdata, rdq.pop_front());
		if (tx_out_valid && tx_out_ready)
			check("tx", {tx_out_last, tx_out_data}, txq.pop_front());
		if (rx_out_valid) check("rx", rx_out_data, rxq.pop_front());
		if (auto_frame_req) afr_cnt++;
	end
	// ----------------------------------------------------------------
	// Main sequence.
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(IDX_CFG, CFG_RESET);
		rd(IDX_SEED_LO, SEED_LO_RESET);
		rd(IDX_SEED_HI, SEED_HI_RESET);
		rd(IDX_SLOT_LO, SLOT_LO_RESET);
		rd(6'h3f, 8'h00);
		bus(1'b1, IDX_IRQ_EN, 8'h01);
		foreach (modes[m]) begin
			setup(modes[m]);
			send_tx(modes[m]);
			send_rx(modes[m], 1'b0);
			bus(1'b1, IDX_CMD, 8'h01);
			foreach (pl[i]) bus(1'b1, IDX_CALC_DATA, pl[i]);
			sd = crc_calc(modes[m], sd);
			rd(IDX_RES_LO, sd[7:0]);
			if (!modes[m][CFG_SHORT]) rd(IDX_RES_HI, sd[15:8]);
		end
		// Zero seed and a single set bit show one step of each shift direction.
		pl = {8'h01};
		for (int h = 0; h < 2; h++) begin
			sd = crc_calc(h ? 8'h6c : 8'h4c, 16'h0000);
			bus(1'b1, IDX_CFG, h ? 8'h6c : 8'h4c);
			bus(1'b1, IDX_SEED_LO, 8'h00);
			bus(1'b1, IDX_SEED_HI, 8'h00);
			bus(1'b1, IDX_CMD, 8'h01);
			bus(1'b1, IDX_CALC_DATA, 8'h01);
			rd(IDX_RES_LO, sd[7:0]);
			rd(IDX_RES_HI, sd[15:8]);
		end
		setup(8'h0c);
		bus(1'b1, IDX_IRQ_CLR, 8'h0f);
		send_rx(8'h0c, 1'b1);
		check("irq", irq, 1'b1);
		rd(IDX_IRQ_STAT, 8'h03);
		bus(1'b1, IDX_IRQ_CLR, 8'h0f);
		send_rx(8'h0c, 1'b0);
		rd(IDX_IRQ_STAT, 8'h02);
		check("irq", irq, 1'b0);
		setup(8'h00);
		send_tx(8'h00);
		send_rx(8'h00, 1'b0);
		bus(1'b1, IDX_SLOT_LO, 8'h02);
		bus(1'b1, IDX_SLOT_TOP, 8'h10);
		ticks(4);
		check("auto frame", afr_cnt, 0);
		send_tx(8'h00);
		for (int p = 0; p < 2; p++) begin
			ticks(257);
			check("auto frame", afr_cnt, p);
			ticks(1);
			check("auto frame", afr_cnt, p + 1);
		end
		check("tx left", txq.size(), 0);
		check("rx left", rxq.size(), 0);
		conclude();
	end
endmodule : testbench
